//--- hw/ccr_map.svh
/*
 Constants for the core register set: condition_flags field positions,
 fixed bits, reset values and register widths.
 Assumes inclusion by bare name from design files under hw/.
*/
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

`define CCR_DATA_W 8
`define CCR_PC_W 16
`define CCR_FLAG_CARRY 0
`define CCR_FLAG_ZERO 1
`define CCR_FLAG_NEG 2
`define CCR_FLAG_MASK 3
`define CCR_FLAG_HALF 4
`define CCR_FIXED_ONES 8'he0
`define CCR_CC_RESET 8'he8
`define CCR_PC_RESET 16'h0000
`define CCR_DATA_RESET 8'h00

`endif

//--- hw/ccr_pkg.sv
/*
 Types shared by the core register set: register selectors, flag-write
 sources and branch conditions.
 Assumes the execution unit drives these codes one operation per cycle.
*/
package ccr_pkg;

   // Destination / source selector for the data registers
   typedef enum logic [2:0] {
      CCR_SEL_NONE = 3'h0,
      CCR_SEL_ACC = 3'h1,
      CCR_SEL_IDX_X = 3'h2,
      CCR_SEL_IDX_Y = 3'h3,
      CCR_SEL_FLAGS = 3'h4,
      CCR_SEL_PC_LOW = 3'h5,
      CCR_SEL_PC_HIGH = 3'h6
   } ccr_sel_t;

   // Kind of ALU operation, decides which flags get updated
   typedef enum logic [2:0] {
      CCR_OP_NONE = 3'h0,
      CCR_OP_ADD = 3'h1,
      CCR_OP_ARITH = 3'h2,
      CCR_OP_LOGIC = 3'h3,
      CCR_OP_SHIFT = 3'h4,
      CCR_OP_BTJ = 3'h5
   } ccr_op_t;

   // Flag-control instruction codes
   typedef enum logic [2:0] {
      CCR_FC_NONE = 3'h0,
      CCR_FC_SET_MASK = 3'h1,
      CCR_FC_CLR_MASK = 3'h2,
      CCR_FC_SET_CARRY = 3'h3,
      CCR_FC_CLR_CARRY = 3'h4
   } ccr_fctl_t;

   // Conditional relative jump conditions
   typedef enum logic [3:0] {
      CCR_JMP_HALF = 4'h0,
      CCR_JMP_NO_HALF = 4'h1,
      CCR_JMP_MASKED = 4'h2,
      CCR_JMP_UNMASKED = 4'h3,
      CCR_JMP_NEG = 4'h4,
      CCR_JMP_POS = 4'h5,
      CCR_JMP_EQ = 4'h6,
      CCR_JMP_NE = 4'h7,
      CCR_JMP_CARRY = 4'h8,
      CCR_JMP_NO_CARRY = 4'h9
   } ccr_jmp_t;

   // Interrupt sequencing state
   typedef enum logic [2:0] {
      CCR_ST_IDLE = 3'b001,
      CCR_ST_IN_ISR = 3'b010,
      CCR_ST_ENTER = 3'b100
   } ccr_state_t;

endpackage

//--- hw/ccr_flag_eval.sv
/*
 Combinational flag evaluator: computes next condition flags from an
 ALU result and tests jump conditions against the current flags.
 Assumes operands and result are presented in the same cycle.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ccr_map.svh"

module ccr_flag_eval (
   input wire ccr_pkg::ccr_op_t op_i,
   input wire logic [7:0] operand_a_i,
   input wire logic [7:0] operand_b_i,
   input wire logic carry_in_i,
   input wire logic [7:0] result_i,
   input wire logic alu_carry_i,
   input wire logic [7:0] flags_i,
   input wire ccr_pkg::ccr_jmp_t jmp_cond_i,
   output logic [7:0] next_flags_o,
   output logic jump_taken_o
);

   // Carry out of bit 3 of a nibble add
   function automatic logic nibble_carry(input logic [3:0] a, input logic [3:0] b, input logic ci);
      logic [4:0] s;
      s = {1'b0, a} + {1'b0, b} + {4'h0, ci};
      return s[4];
   endfunction

   always_comb begin
      next_flags_o = flags_i;
      if (op_i == ccr_pkg::CCR_OP_ADD) begin
         next_flags_o[`CCR_FLAG_HALF] = nibble_carry(operand_a_i[3:0], operand_b_i[3:0], carry_in_i); // RULE8
      end
      if (op_i != ccr_pkg::CCR_OP_NONE && op_i != ccr_pkg::CCR_OP_BTJ) begin
         next_flags_o[`CCR_FLAG_NEG] = result_i[7]; // RULE13
         next_flags_o[`CCR_FLAG_ZERO] = (result_i == 8'h00); // RULE14
      end
      if (op_i == ccr_pkg::CCR_OP_ADD || op_i == ccr_pkg::CCR_OP_ARITH) begin
         next_flags_o[`CCR_FLAG_CARRY] = alu_carry_i; // RULE15
      end
      if (op_i == ccr_pkg::CCR_OP_SHIFT || op_i == ccr_pkg::CCR_OP_BTJ) begin
         next_flags_o[`CCR_FLAG_CARRY] = alu_carry_i; // RULE16
      end
   end

   always_comb begin
      case (jmp_cond_i)
         ccr_pkg::CCR_JMP_HALF: jump_taken_o = flags_i[`CCR_FLAG_HALF]; // RULE9
         ccr_pkg::CCR_JMP_NO_HALF: jump_taken_o = !flags_i[`CCR_FLAG_HALF]; // RULE9
         ccr_pkg::CCR_JMP_MASKED: jump_taken_o = flags_i[`CCR_FLAG_MASK]; // RULE17
         ccr_pkg::CCR_JMP_UNMASKED: jump_taken_o = !flags_i[`CCR_FLAG_MASK]; // RULE17
         ccr_pkg::CCR_JMP_NEG: jump_taken_o = flags_i[`CCR_FLAG_NEG]; // RULE17
         ccr_pkg::CCR_JMP_POS: jump_taken_o = !flags_i[`CCR_FLAG_NEG]; // RULE17
         ccr_pkg::CCR_JMP_EQ: jump_taken_o = flags_i[`CCR_FLAG_ZERO]; // RULE17
         ccr_pkg::CCR_JMP_NE: jump_taken_o = !flags_i[`CCR_FLAG_ZERO]; // RULE17
         ccr_pkg::CCR_JMP_CARRY: jump_taken_o = flags_i[`CCR_FLAG_CARRY]; // RULE16
         ccr_pkg::CCR_JMP_NO_CARRY: jump_taken_o = !flags_i[`CCR_FLAG_CARRY]; // RULE16
         default: jump_taken_o = 1'b0;
      endcase
   end

endmodule
`default_nettype wire

//--- hw/ccr_irq_pending.sv
/*
 Pending-interrupt latch: holds requests that arrive while the mask is
 set and offers them as soon as the mask is clear.
 Assumes request lines are synchronous one-cycle or level pulses.
*/
`timescale 1ns/1ns
`default_nettype none

module ccr_irq_pending #(
   parameter int N_IRQ = 4
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire logic [N_IRQ-1:0] irq_req_i,
   input wire logic [N_IRQ-1:0] irq_ack_i,
   input wire logic mask_i,
   output logic [N_IRQ-1:0] pending_o,
   output logic irq_take_o
);

   // A request arriving in the ack cycle survives: set wins over clear
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         pending_o <= '0;
      end else if (clk_en_i) begin
         pending_o <= (pending_o & ~irq_ack_i) | irq_req_i; // RULE11
      end
   end

   // No priority gate against the running routine: clear mask means take
   assign irq_take_o = !mask_i && (pending_o != '0); // RULE12

endmodule
`default_nettype wire

//--- hw/ccr_core_regs.sv
/*
 Core register set of an 8-bit CPU: accumulator, two index registers,
 program counter and condition_flags, plus interrupt mask sequencing.
 Assumes the execution unit drives at most one write per register per
 cycle and owns the stack memory; this block only supplies and accepts
 the stacked values.
*/
// What this block does
// (RULE1) Registers reached only by dedicated ports, unmapped
// (RULE2) One 8-bit accumulator for operands and results
// (RULE3) Two 8-bit index registers for addresses
// (RULE4) Interrupt context save and restore skip index Y
// (RULE5) 16-bit program counter built of low/high bytes
// (RULE6) Flags layout 111HINZC, reset 111x1xxx
// (RULE7) Flags pushable, poppable, individually tested and set
// (RULE8) Half carry from bit 3 on adds only
// (RULE9) Half carry tested by paired relative jumps
// (RULE10) Mask set on entry/instruction, cleared by return/instruction
// (RULE11) Masked requests latched pending, not lost
// (RULE12) Clearing mask in routine services pending immediately
// (RULE13) Negative flag copies result bit 7
// (RULE14) Zero flag set when result is zero
// (RULE15) Carry from arithmetic, forced by set/clear carry
// (RULE16) Carry also from bit-test-branch, shifts, rotates
// (RULE17) Mask, negative, zero tested by paired jumps
// (RULE18) Upper three flag bits fixed at one
`timescale 1ns/1ns
`default_nettype none
`include "ccr_map.svh"

module ccr_core_regs #(
   parameter int N_IRQ = 4
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   // Register write port from the execution unit
   input wire ccr_pkg::ccr_sel_t wr_sel_i,
   input wire logic [7:0] wr_data_i,
   // Program counter load and increment
   input wire logic pc_load_i,
   input wire logic [15:0] pc_load_value_i,
   input wire logic pc_inc_i,
   // ALU flag update
   input wire ccr_pkg::ccr_op_t alu_op_i,
   input wire logic [7:0] alu_a_i,
   input wire logic [7:0] alu_b_i,
   input wire logic [7:0] alu_result_i,
   input wire logic alu_carry_i,
   input wire ccr_pkg::ccr_fctl_t flag_ctl_i,
   // Jump condition test
   input wire ccr_pkg::ccr_jmp_t jmp_cond_i,
   output logic jump_taken_o,
   // Interrupt interface
   input wire logic [N_IRQ-1:0] irq_req_i,
   input wire logic [N_IRQ-1:0] irq_ack_i,
   input wire logic trap_i,
   input wire logic irq_enter_i,
   input wire logic irq_return_i,
   input wire logic [7:0] ret_flags_i,
   input wire logic [7:0] ret_acc_i,
   input wire logic [7:0] ret_idx_x_i,
   input wire logic [15:0] ret_pc_i,
   output logic irq_take_o,
   output logic [N_IRQ-1:0] irq_pending_o,
   output logic in_isr_o,
   // Register views
   output logic [7:0] acc_o,
   output logic [7:0] idx_x_o,
   output logic [7:0] idx_y_o,
   output logic [7:0] program_counter_low_o,
   output logic [7:0] program_counter_high_o,
   output logic [7:0] condition_flags_o,
   output logic [7:0] ctx_flags_o,
   output logic [7:0] ctx_acc_o,
   output logic [7:0] ctx_idx_x_o,
   output logic [15:0] ctx_pc_o
);

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [7:0] acc;
   logic [7:0] idx_x;
   logic [7:0] idx_y;
   logic [15:0] program_counter;
   logic [4:0] flag_bits;
   logic [7:0] condition_flags;
   logic [7:0] next_flags_alu;
   logic mask_pending_take;
   ccr_pkg::ccr_state_t state;
   ccr_pkg::ccr_state_t next_state;

   // Upper bits are not stored at all, so no write can disturb them
   assign condition_flags = `CCR_FIXED_ONES | {3'b000, flag_bits}; // RULE6 RULE18

   // ------------------------------------------------------------
   // Flag evaluation
   // ------------------------------------------------------------
   ccr_flag_eval u_flag_eval (
      .op_i(alu_op_i),
      .operand_a_i(alu_a_i),
      .operand_b_i(alu_b_i),
      .carry_in_i(1'b0),
      .result_i(alu_result_i),
      .alu_carry_i(alu_carry_i),
      .flags_i(condition_flags),
      .jmp_cond_i(jmp_cond_i),
      .next_flags_o(next_flags_alu),
      .jump_taken_o(jump_taken_o)
   );

   // ------------------------------------------------------------
   // Pending interrupts
   // ------------------------------------------------------------
   ccr_irq_pending #(
      .N_IRQ(N_IRQ)
   ) u_irq_pending (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .clk_en_i(clk_en_i),
      .irq_req_i(irq_req_i),
      .irq_ack_i(irq_ack_i),
      .mask_i(flag_bits[`CCR_FLAG_MASK]),
      .pending_o(irq_pending_o),
      .irq_take_o(mask_pending_take)
   );

   // Trap ignores the mask; maskable sources wait for it to clear
   assign irq_take_o = mask_pending_take || trap_i; // RULE10

   // ------------------------------------------------------------
   // Data registers
   // ------------------------------------------------------------
   // Only dedicated select codes reach these; no address decode exists
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         acc <= `CCR_DATA_RESET;
      end else if (clk_en_i) begin
         if (irq_return_i) begin
            acc <= ret_acc_i; // RULE4
         end else if (wr_sel_i == ccr_pkg::CCR_SEL_ACC) begin
            acc <= wr_data_i; // RULE1 RULE2
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         idx_x <= `CCR_DATA_RESET;
      end else if (clk_en_i) begin
         if (irq_return_i) begin
            idx_x <= ret_idx_x_i; // RULE4
         end else if (wr_sel_i == ccr_pkg::CCR_SEL_IDX_X) begin
            idx_x <= wr_data_i; // RULE3
         end
      end
   end

   // Y is deliberately outside the interrupt save/restore path
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         idx_y <= `CCR_DATA_RESET;
      end else if (clk_en_i) begin
         if (wr_sel_i == ccr_pkg::CCR_SEL_IDX_Y) begin
            idx_y <= wr_data_i; // RULE3 RULE4
         end
      end
   end

   // ------------------------------------------------------------
   // Program counter
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         program_counter <= `CCR_PC_RESET;
      end else if (clk_en_i) begin
         if (irq_return_i) begin
            program_counter <= ret_pc_i;
         end else if (pc_load_i) begin
            program_counter <= pc_load_value_i; // RULE5
         end else if (wr_sel_i == ccr_pkg::CCR_SEL_PC_LOW) begin
            program_counter[7:0] <= wr_data_i; // RULE5
         end else if (wr_sel_i == ccr_pkg::CCR_SEL_PC_HIGH) begin
            program_counter[15:8] <= wr_data_i; // RULE5
         end else if (pc_inc_i) begin
            program_counter <= program_counter + 16'h0001;
         end
      end
   end

   // ------------------------------------------------------------
   // Condition flags
   // ------------------------------------------------------------
   // Reset leaves H,N,Z,C undefined; zero is used as the concrete value
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         flag_bits <= 5'(`CCR_CC_RESET);
      end else if (clk_en_i) begin
         if (irq_enter_i) begin
            flag_bits[`CCR_FLAG_MASK] <= 1'b1; // RULE10
         end else if (irq_return_i) begin
            flag_bits <= ret_flags_i[4:0]; // RULE7 RULE10 RULE18
         end else if (wr_sel_i == ccr_pkg::CCR_SEL_FLAGS) begin
            flag_bits <= wr_data_i[4:0]; // RULE7 RULE18
         end else begin
            flag_bits <= next_flags_alu[4:0]; // RULE13 RULE14
            case (flag_ctl_i)
               ccr_pkg::CCR_FC_SET_MASK: flag_bits[`CCR_FLAG_MASK] <= 1'b1; // RULE10
               ccr_pkg::CCR_FC_CLR_MASK: flag_bits[`CCR_FLAG_MASK] <= 1'b0; // RULE10 RULE12
               ccr_pkg::CCR_FC_SET_CARRY: flag_bits[`CCR_FLAG_CARRY] <= 1'b1; // RULE15
               ccr_pkg::CCR_FC_CLR_CARRY: flag_bits[`CCR_FLAG_CARRY] <= 1'b0; // RULE15
               default: ;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Interrupt routine tracking
   // ------------------------------------------------------------
   always_comb begin
      case (state)
         ccr_pkg::CCR_ST_IDLE: next_state = irq_enter_i ? ccr_pkg::CCR_ST_ENTER : ccr_pkg::CCR_ST_IDLE;
         // A return right after entry must not be lost
         ccr_pkg::CCR_ST_ENTER: next_state = irq_return_i ? ccr_pkg::CCR_ST_IDLE : ccr_pkg::CCR_ST_IN_ISR;
         ccr_pkg::CCR_ST_IN_ISR: next_state = irq_return_i ? ccr_pkg::CCR_ST_IDLE : ccr_pkg::CCR_ST_IN_ISR;
         default: next_state = ccr_pkg::CCR_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         state <= ccr_pkg::CCR_ST_IDLE;
      end else if (clk_en_i) begin
         state <= next_state;
      end
   end

   assign in_isr_o = (state != ccr_pkg::CCR_ST_IDLE);

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign acc_o = acc;
   assign idx_x_o = idx_x;
   assign idx_y_o = idx_y;
   assign program_counter_low_o = program_counter[7:0];
   assign program_counter_high_o = program_counter[15:8];
   assign condition_flags_o = condition_flags; // RULE6
   // Context offered for stacking on interrupt entry, Y excluded
   assign ctx_flags_o = condition_flags; // RULE4 RULE7
   assign ctx_acc_o = acc;
   assign ctx_idx_x_o = idx_x;
   assign ctx_pc_o = program_counter;

endmodule
`default_nettype wire

//--- tb/ccr_core_regs_chk.sv
/*
 Checker for ccr_core_regs: flag, register and interrupt relations.
 Assumes it is bound onto the top module and sees its ports only.
*/
`timescale 1ns/1ns
`default_nettype none
module ccr_core_regs_chk #(
   parameter int N_IRQ = 4
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire ccr_pkg::ccr_sel_t wr_sel_i,
   input wire logic [7:0] wr_data_i,
   input wire logic pc_load_i,
   input wire logic pc_inc_i,
   input wire ccr_pkg::ccr_op_t alu_op_i,
   input wire logic [7:0] alu_a_i,
   input wire logic [7:0] alu_b_i,
   input wire logic [7:0] alu_result_i,
   input wire ccr_pkg::ccr_fctl_t flag_ctl_i,
   input wire ccr_pkg::ccr_jmp_t jmp_cond_i,
   input wire logic jump_taken_o,
   input wire logic [N_IRQ-1:0] irq_req_i,
   input wire logic trap_i,
   input wire logic irq_enter_i,
   input wire logic irq_return_i,
   input wire logic irq_take_o,
   input wire logic [N_IRQ-1:0] irq_pending_o,
   input wire logic in_isr_o,
   input wire logic [7:0] acc_o,
   input wire logic [7:0] idx_y_o,
   input wire logic [7:0] program_counter_low_o,
   input wire logic [7:0] program_counter_high_o,
   input wire logic [7:0] condition_flags_o
);
   // Flags follow the ALU only when no higher-priority writer is active
   logic quiet;
   logic half_exp;
   logic [15:0] pc_now;
   assign quiet = clk_en_i && !irq_enter_i && !irq_return_i && wr_sel_i != ccr_pkg::CCR_SEL_FLAGS;
   assign half_exp = ({1'b0, alu_a_i[3:0]} + {1'b0, alu_b_i[3:0]}) > 5'h0f;
   assign pc_now = {program_counter_high_o, program_counter_low_o};
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   fixed_ones_a: assert property (condition_flags_o[7:5] == 3'b111)
      else $error("upper flag bits not one");
   acc_load_a: assert property (clk_en_i && wr_sel_i == ccr_pkg::CCR_SEL_ACC && !irq_return_i
      |=> acc_o == $past(wr_data_i)) else $error("accumulator write lost");
   y_kept_a: assert property (irq_return_i && wr_sel_i != ccr_pkg::CCR_SEL_IDX_Y |=> $stable(idx_y_o))
      else $error("index y changed by return");
   pc_step_a: assert property (clk_en_i && pc_inc_i && !pc_load_i && !irq_return_i
      && wr_sel_i < ccr_pkg::CCR_SEL_PC_LOW |=> pc_now == $past(pc_now) + 16'h0001)
      else $error("program counter increment wrong");
   half_add_a: assert property (quiet && alu_op_i == ccr_pkg::CCR_OP_ADD |=> condition_flags_o[4] == $past(half_exp))
      else $error("half carry wrong after add");
   half_keep_a: assert property (quiet && alu_op_i != ccr_pkg::CCR_OP_ADD |=> $stable(condition_flags_o[4]))
      else $error("half carry changed by non-add");
   neg_zero_a: assert property (quiet && alu_op_i inside {[ccr_pkg::CCR_OP_ADD:ccr_pkg::CCR_OP_SHIFT]}
      |=> condition_flags_o[2:1] == {$past(alu_result_i[7]), $past(alu_result_i) == 8'h00})
      else $error("negative or zero flag wrong");
   mask_enter_a: assert property (clk_en_i && irq_enter_i |=> condition_flags_o[3] && in_isr_o)
      else $error("entry did not mask");
   take_a: assert property (irq_take_o == ((|irq_pending_o && !condition_flags_o[3]) || trap_i))
      else $error("interrupt take wrong");
   pend_latch_a: assert property (clk_en_i && irq_req_i[0] |=> irq_pending_o[0])
      else $error("request not latched");
   carry_set_a: assert property (quiet && flag_ctl_i == ccr_pkg::CCR_FC_SET_CARRY |=> condition_flags_o[0])
      else $error("set carry ignored");
   jump_half_a: assert property (jmp_cond_i == ccr_pkg::CCR_JMP_HALF |-> jump_taken_o == condition_flags_o[4])
      else $error("half carry jump wrong");
   jump_ne_a: assert property (jmp_cond_i == ccr_pkg::CCR_JMP_NE |-> jump_taken_o != condition_flags_o[1])
      else $error("not-equal jump wrong");
endmodule
bind ccr_core_regs ccr_core_regs_chk #(.N_IRQ(N_IRQ)) u_chk (.clk_i, .reset_n_i, .clk_en_i, .wr_sel_i,
   .wr_data_i, .pc_load_i, .pc_inc_i, .alu_op_i, .alu_a_i, .alu_b_i, .alu_result_i, .flag_ctl_i,
   .jmp_cond_i, .jump_taken_o, .irq_req_i, .trap_i, .irq_enter_i, .irq_return_i, .irq_take_o,
   .irq_pending_o, .in_isr_o, .acc_o, .idx_y_o, .program_counter_low_o, .program_counter_high_o,
   .condition_flags_o);
`default_nettype wire

//--- tb/ccr_alu_model.sv
/*
 Behavioural ALU standing in for the execution unit.
 Assumes operands are held for the whole cycle; answers combinationally.
*/
`timescale 1ns/1ns
`default_nettype none
module ccr_alu_model (
   input wire ccr_pkg::ccr_op_t op_i,
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   output logic [7:0] result_o,
   output logic carry_o
);
   // Subtract yields borrow in the carry position, bit test copies the tested bit
   always_comb begin
      case (op_i)
         ccr_pkg::CCR_OP_ADD: {carry_o, result_o} = {1'b0, a_i} + {1'b0, b_i};
         ccr_pkg::CCR_OP_ARITH: {carry_o, result_o} = {1'b0, a_i} - {1'b0, b_i};
         ccr_pkg::CCR_OP_LOGIC: {carry_o, result_o} = {1'b0, a_i & b_i};
         ccr_pkg::CCR_OP_SHIFT: {carry_o, result_o} = {a_i, 1'b0};
         ccr_pkg::CCR_OP_BTJ: {carry_o, result_o} = {a_i[b_i[2:0]], a_i};
         default: {carry_o, result_o} = 9'h000;
      endcase
   end
endmodule
`default_nettype wire

//--- tb/cpu_core_registers_flags_tb.sv
/*
 Self-checking bench for ccr_core_regs with a behavioural ALU.
 Assumes fixed one-cycle register latency; inputs move 1 ns after edges.
*/
`timescale 1ns/1ns
`default_nettype none
module cpu_core_registers_flags_tb;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic clk_en_i = 1'b1;
   ccr_pkg::ccr_sel_t wr_sel_i;
   ccr_pkg::ccr_op_t alu_op_i;
   ccr_pkg::ccr_fctl_t flag_ctl_i;
   ccr_pkg::ccr_jmp_t jmp_cond_i;
   logic pc_load_i, pc_inc_i, alu_carry_i, jump_taken_o, trap_i, irq_enter_i, irq_return_i, irq_take_o, in_isr_o;
   logic [3:0] irq_req_i, irq_ack_i, irq_pending_o;
   logic [7:0] wr_data_i, alu_a_i, alu_b_i, alu_result_i, ret_flags_i, ret_acc_i, ret_idx_x_i;
   logic [7:0] acc_o, idx_x_o, idx_y_o, program_counter_low_o, program_counter_high_o, condition_flags_o;
   logic [7:0] ctx_flags_o, ctx_acc_o, ctx_idx_x_o;
   logic [15:0] pc_load_value_i, ret_pc_i, ctx_pc_o;
   int mismatches = 0;
   int total_checks = 0;
   always #2 clk_i = ~clk_i;
   ccr_alu_model u_alu (.op_i(alu_op_i), .a_i(alu_a_i), .b_i(alu_b_i), .result_o(alu_result_i),
      .carry_o(alu_carry_i));
   ccr_core_regs #(.N_IRQ(4)) uut (.clk_i, .reset_n_i, .clk_en_i, .wr_sel_i, .wr_data_i, .pc_load_i,
      .pc_load_value_i, .pc_inc_i, .alu_op_i, .alu_a_i, .alu_b_i, .alu_result_i, .alu_carry_i, .flag_ctl_i,
      .jmp_cond_i, .jump_taken_o, .irq_req_i, .irq_ack_i, .trap_i, .irq_enter_i, .irq_return_i, .ret_flags_i,
      .ret_acc_i, .ret_idx_x_i, .ret_pc_i, .irq_take_o, .irq_pending_o, .in_isr_o, .acc_o, .idx_x_o, .idx_y_o,
      .program_counter_low_o, .program_counter_high_o, .condition_flags_o, .ctx_flags_o, .ctx_acc_o,
      .ctx_idx_x_o, .ctx_pc_o);
   // ----------------------------------------
   // Shared drive and compare tasks
   // ----------------------------------------
   task automatic idle();
      wr_sel_i = ccr_pkg::CCR_SEL_NONE;
      alu_op_i = ccr_pkg::CCR_OP_NONE;
      flag_ctl_i = ccr_pkg::CCR_FC_NONE;
      jmp_cond_i = ccr_pkg::CCR_JMP_HALF;
      {pc_load_i, pc_inc_i, irq_req_i, irq_ack_i, trap_i, irq_enter_i, irq_return_i} = 13'h0000;
      {wr_data_i, alu_a_i, alu_b_i, ret_flags_i, ret_acc_i, ret_idx_x_i, pc_load_value_i, ret_pc_i} = 80'h0;
   endtask
   task automatic step();
      @(posedge clk_i);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input ccr_pkg::ccr_sel_t s, input logic [7:0] d);
      wr_sel_i = s;
      wr_data_i = d;
      step();
      idle();
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      chk(condition_flags_o, 16'h00e8);
      chk({acc_o, idx_x_o}, 16'h0000);
      chk({program_counter_high_o, program_counter_low_o}, 16'h0000);
      chk({idx_y_o, irq_pending_o, in_isr_o}, 16'h0000);
   endtask
   task automatic t_regs();
      wr(ccr_pkg::CCR_SEL_ACC, 8'h55);
      wr(ccr_pkg::CCR_SEL_IDX_X, 8'ha5);
      wr(ccr_pkg::CCR_SEL_IDX_Y, 8'h3c);
      chk({acc_o, idx_x_o}, 16'h55a5);
      chk(idx_y_o, 16'h003c);
      wr(ccr_pkg::CCR_SEL_FLAGS, 8'h1f);
      chk(condition_flags_o, 16'h00ff);
      wr(ccr_pkg::CCR_SEL_PC_LOW, 8'hff);
      wr(ccr_pkg::CCR_SEL_PC_HIGH, 8'h12);
      pc_inc_i = 1'b1;
      step();
      idle();
      chk({program_counter_high_o, program_counter_low_o}, 16'h1300);
      pc_load_i = 1'b1;
      pc_load_value_i = 16'hbeef;
      step();
      idle();
      chk({program_counter_high_o, program_counter_low_o}, 16'hbeef);
      clk_en_i = 1'b0;
      wr(ccr_pkg::CCR_SEL_ACC, 8'h99);
      clk_en_i = 1'b1;
      chk(acc_o, 16'h0055);
   endtask
   task automatic t_alu();
      ccr_pkg::ccr_op_t ops[8] = '{ccr_pkg::CCR_OP_ADD, ccr_pkg::CCR_OP_ADD, ccr_pkg::CCR_OP_ARITH,
         ccr_pkg::CCR_OP_LOGIC, ccr_pkg::CCR_OP_SHIFT, ccr_pkg::CCR_OP_ADD, ccr_pkg::CCR_OP_BTJ, ccr_pkg::CCR_OP_SHIFT};
      logic [7:0] av[8] = '{8'h08, 8'h80, 8'h00, 8'hf0, 8'h81, 8'h0f, 8'h01, 8'h40};
      logic [7:0] bv[8] = '{8'h08, 8'h80, 8'h01, 8'h0f, 8'h00, 8'h01, 8'h00, 8'h00};
      logic [7:0] fv[8] = '{8'hf8, 8'heb, 8'hed, 8'heb, 8'he9, 8'hf8, 8'hf9, 8'hfc};
      ccr_pkg::ccr_fctl_t fc[4] = '{ccr_pkg::CCR_FC_SET_CARRY, ccr_pkg::CCR_FC_CLR_CARRY,
         ccr_pkg::CCR_FC_CLR_MASK, ccr_pkg::CCR_FC_SET_MASK};
      logic [7:0] ff[4] = '{8'hfd, 8'hfc, 8'hf4, 8'hfc};
      wr(ccr_pkg::CCR_SEL_FLAGS, 8'h08);
      for (int i = 0; i < 8; i++) begin
         alu_op_i = ops[i];
         alu_a_i = av[i];
         alu_b_i = bv[i];
         step();
         idle();
         chk(condition_flags_o, fv[i]);
      end
      for (int i = 0; i < 4; i++) begin
         flag_ctl_i = fc[i];
         step();
         idle();
         chk(condition_flags_o, ff[i]);
      end
   endtask
   task automatic t_jump();
      for (int k = 0; k < 2; k++) begin
         wr(ccr_pkg::CCR_SEL_FLAGS, k ? 8'h1f : 8'h00);
         for (int i = 0; i < 10; i++) begin
            jmp_cond_i = ccr_pkg::ccr_jmp_t'(i);
            step();
            chk(jump_taken_o, (k != 0) ^ i[0]);
         end
      end
      idle();
   endtask
   task automatic t_irq();
      wr(ccr_pkg::CCR_SEL_FLAGS, 8'h08);
      wr(ccr_pkg::CCR_SEL_IDX_Y, 8'h77);
      irq_req_i = 4'h1;
      step();
      idle();
      chk({irq_pending_o, irq_take_o}, 16'h0002);
      flag_ctl_i = ccr_pkg::CCR_FC_CLR_MASK;
      step();
      idle();
      chk(irq_take_o, 16'h0001);
      irq_enter_i = 1'b1;
      irq_ack_i = 4'h1;
      step();
      idle();
      chk({in_isr_o, condition_flags_o[3], irq_take_o, irq_pending_o}, 16'h0060);
      chk({ctx_acc_o, ctx_flags_o}, 16'h55e8);
      chk(ctx_idx_x_o, 16'h00a5);
      chk(ctx_pc_o, 16'hbeef);
      trap_i = 1'b1;
      step();
      chk(irq_take_o, 16'h0001);
      trap_i = 1'b0;
      irq_return_i = 1'b1;
      {ret_flags_i, ret_acc_i, ret_idx_x_i, ret_pc_i} = 40'h001122abcd;
      step();
      idle();
      chk({acc_o, idx_x_o}, 16'h1122);
      chk({program_counter_high_o, program_counter_low_o}, 16'habcd);
      chk({idx_y_o, condition_flags_o}, 16'h77e0);
      step();
      chk(in_isr_o, 16'h0000);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      idle();
      repeat (16) @(posedge clk_i);
      #1;
      reset_n_i = 1'b1;
      t_reset();
      t_regs();
      t_alu();
      t_jump();
      t_irq();
      results();
   end
endmodule
`default_nettype wire
